/* File: verilog/ucfr_top.sv */
// Behaviour
// RULE_01 - Hold 16-bit under-current threshold as fault limit
// RULE_02 - Standard response layout, sets under-current status bit
// RULE_03 - Any fault pulls alert low, sets status
// RULE_04 - Mode 00: keep running, ignore fault
// RULE_05 - Mode 01: run for delay, then retry setting
// RULE_06 - Mode 10: disable at once, then retry setting
// RULE_07 - Mode 11: off while fault, resume after
// RULE_08 - Retry 000: no restart, off until cleared
// RULE_09 - Retry 1..6: that many attempts, then latch off
// RULE_10 - Attempt starts spaced by delay field units
// RULE_11 - Retry 111: retry until off or other fault
// RULE_12 - Delay field value is plain unit count
// RULE_13 - Continue-operating unit is 10 ms
// RULE_14 - Restart interval unit is 8.2 ms
// RULE_15 - Bit clear, clear-all, reset, off-on clear fault
// RULE_16 - Fault when measured current below threshold
// RULE_17 - Threshold and action byte read back unchanged
`timescale 1ns/100ps
module ucfr_top import ucfr_pkg::*; #(
    parameter int CONT_CYCLES  = CONT_UNIT_CYCLES,
    parameter int RETRY_CYCLES = RETRY_UNIT_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    output logic      [15:0] cmd_rdata,
    output logic             cmd_hit,
    input  wire logic [15:0] iout_meas,
    input  wire logic        output_on_cmd,
    input  wire logic        clear_faults,
    input  wire logic        status_uc_clear,
    input  wire logic        other_fault_off,
    output logic             output_enable,
    output logic             uc_fault_status,
    output logic             bus_alert_output_out,
    output logic             bus_alert_output_oe
);

    // ------------------------------------------------------------
    // Command registers
    // ------------------------------------------------------------
    logic [15:0]  thr_q, thr_d;
    logic [7:0]   act_q, act_d;
    logic [15:0]  rdata_q, rdata_d;
    logic         hit_q, hit_d;

    // Decode of command writes and reads
    always_comb begin
        thr_d   = thr_q;
        act_d   = act_q;
        rdata_d = rdata_q;
        hit_d   = 1'b0;
        if (cmd_valid) begin
            // RULE_17 store as written
            if (cmd_code == CMD_THRESHOLD) begin
                hit_d   = 1'b1;
                rdata_d = thr_q;
                if (cmd_write) begin
                    thr_d = cmd_wdata;
                end
            end else if (cmd_code == CMD_ACTION) begin
                hit_d   = 1'b1;
                rdata_d = {8'h00, act_q};
                if (cmd_write) begin
                    act_d = cmd_wdata[7:0];
                end
            end else begin
                rdata_d = 16'h0000;
            end
        end
    end

    // Command register storage
    always_ff @(posedge clock) begin
        if (reset) begin
            thr_q   <= THRESHOLD_RESET;
            act_q   <= ACTION_RESET;
            rdata_q <= 16'h0000;
            hit_q   <= 1'b0;
        end else begin
            thr_q   <= thr_d;
            act_q   <= act_d;
            rdata_q <= rdata_d;
            hit_q   <= hit_d;
        end
    end

    assign cmd_rdata = rdata_q;
    assign cmd_hit   = hit_q;

    // ------------------------------------------------------------
    // Fault detection and clearing
    // ------------------------------------------------------------
    logic [1:0]  resp;
    logic [2:0]  retries;
    logic [2:0]  delay_units;
    logic        fault;
    logic        below;
    logic        clr;
    logic        on_q;

    assign resp        = act_q[RESP_MSB:RESP_LSB];
    assign retries     = act_q[RETRY_MSB:RETRY_LSB];
    assign delay_units = act_q[DELAY_MSB:DELAY_LSB];

    // RULE_16 signed mantissa compare
    // RULE_01 threshold is the limit
    assign below = $signed(iout_meas[MANT_MSB:0]) < $signed(thr_q[MANT_MSB:0]);
    assign fault = output_enable && below;

    // RULE_15 clear sources
    assign clr = clear_faults || status_uc_clear || (output_on_cmd && !on_q);

    always_ff @(posedge clock) begin
        if (reset) begin
            on_q <= 1'b0;
        end else begin
            on_q <= output_on_cmd;
        end
    end

    // ------------------------------------------------------------
    // Response state machine
    // ------------------------------------------------------------
    ucfr_state_e  st_q, st_d;
    logic [2:0]   left_q, left_d;
    logic         stat_q, stat_d;
    logic         en_q, en_d;
    ucfr_timer_if tif ();

    // Next state, attempts, status and output enable
    always_comb begin
        st_d           = st_q;
        left_d         = left_q;
        tif.start      = 1'b0;
        tif.retry_unit = 1'b0;
        tif.units      = delay_units;
        // RULE_02 under-current bit
        // RULE_03 set wins over clear
        stat_d         = (stat_q && !clr) || (fault && st_q != ST_HOLD && st_q != ST_TRY);
        case (st_q)
            ST_RUN: begin
                if (fault && !clr) begin
                    // RULE_04 ignore
                    if (resp == RESP_DELAY) begin
                        // RULE_05 keep running
                        tif.start = 1'b1;
                        st_d      = ST_DELAY;
                    end else if (resp == RESP_RETRY) begin
                        // RULE_06 disable now
                        // RULE_08 no retry latches
                        st_d           = (retries == RETRY_NONE) ? ST_LATCH : ST_WAIT;
                        left_d         = retries;
                        tif.start      = 1'b1;
                        tif.retry_unit = 1'b1;
                    end else if (resp == RESP_HOLD) begin
                        st_d = ST_HOLD;
                    end
                end
            end
            ST_DELAY: begin
                if (tif.done) begin
                    st_d           = !fault ? ST_RUN : (retries == RETRY_NONE) ? ST_LATCH : ST_WAIT;
                    left_d         = retries;
                    tif.start      = fault;
                    tif.retry_unit = 1'b1;
                end
            end
            ST_WAIT: begin
                // RULE_10 spacing of starts
                if (tif.done) begin
                    st_d           = ST_TRY;
                    tif.start      = 1'b1;
                    tif.retry_unit = 1'b1;
                end
            end
            ST_TRY: begin
                if (fault) begin
                    stat_d = 1'b1;
                    // Rearm an expired timer so WAIT can end
                    tif.start      = tif.done;
                    tif.retry_unit = 1'b1;
                    // RULE_09 count attempts
                    // RULE_11 endless retry
                    if (retries == RETRY_FOREVER) begin
                        st_d = ST_WAIT;
                    end else begin
                        left_d = left_q - 3'h1;
                        st_d   = (left_q == 3'h1) ? ST_LATCH : ST_WAIT;
                    end
                end else if (tif.done) begin
                    st_d = ST_RUN;
                end
            end
            ST_HOLD: begin
                // RULE_07 resume when gone
                st_d = below ? ST_HOLD : ST_RUN;
            end
            default: begin
                st_d = ST_LATCH;
            end
        endcase
        if (other_fault_off && st_q != ST_RUN) begin
            st_d = ST_LATCH;
        end
        // RULE_15 clear returns to run
        if (clr || !output_on_cmd) begin
            st_d = ST_RUN;
        end
        en_d = output_on_cmd && !clr || (output_on_cmd && on_q);
        en_d = en_d && (st_d == ST_RUN || st_d == ST_DELAY || st_d == ST_TRY);
    end

    // State machine registers
    always_ff @(posedge clock) begin
        if (reset) begin
            st_q   <= ST_RUN;
            left_q <= 3'h0;
            stat_q <= 1'b0;
            en_q   <= 1'b0;
        end else begin
            st_q   <= st_d;
            left_q <= left_d;
            stat_q <= stat_d;
            en_q   <= en_d;
        end
    end

    ucfr_timer #(
        .CONT_CYCLES  (CONT_CYCLES),
        .RETRY_CYCLES (RETRY_CYCLES)
    ) u_timer (
        .clock (clock),
        .reset (reset),
        .tif   (tif.tmr)
    );

    // Open-drain alert pulled low while status is set
    assign output_enable        = en_q;
    assign uc_fault_status      = stat_q;
    assign bus_alert_output_out = 1'b0;
    assign bus_alert_output_oe  = stat_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence run_fault_s;
        st_q == ST_RUN && fault && !clr && output_on_cmd;
    endsequence

    chk_thr_store: assert property (cmd_valid && cmd_write && cmd_code == CMD_THRESHOLD // RULE_17
        |=> thr_q == $past(cmd_wdata)) else $error("threshold not stored");
    chk_fault_alert: assert property (fault && st_q == ST_RUN |=> stat_q && bus_alert_output_oe) // RULE_03
        else $error("fault did not raise alert");
    chk_ignore_runs: assert property (run_fault_s ##0 resp == RESP_IGNORE |=> st_q == ST_RUN && en_q) // RULE_04
        else $error("ignore mode interrupted output");
    chk_delay_runs: assert property (run_fault_s ##0 resp == RESP_DELAY |=> st_q == ST_DELAY && en_q) // RULE_05
        else $error("delay mode did not keep running");
    chk_disable_now: assert property (run_fault_s ##0 resp == RESP_RETRY |=> !en_q) // RULE_06
        else $error("retry mode left output on");
    chk_no_retry: assert property (run_fault_s ##0 resp == RESP_RETRY && retries == RETRY_NONE // RULE_08
        |=> st_q == ST_LATCH) else $error("zero retries did not latch");
    chk_hold_off: assert property (st_q == ST_HOLD && below && !clr && output_on_cmd |=> !en_q) // RULE_07
        else $error("output on during hold");
    chk_hold_resume: assert property (st_q == ST_HOLD && !below && output_on_cmd && on_q // RULE_07
        && !other_fault_off |=> en_q) else $error("hold did not resume output");
    chk_last_try: assert property (st_q == ST_TRY && fault && left_q == 3'h1 && retries != RETRY_FOREVER // RULE_09
        && !clr && output_on_cmd |=> st_q == ST_LATCH) else $error("last attempt did not latch");
    chk_endless_try: assert property (st_q == ST_TRY && fault && retries == RETRY_FOREVER && !clr // RULE_11
        && output_on_cmd && !other_fault_off |=> st_q == ST_WAIT) else $error("endless retry stopped");
    chk_clear_run: assert property (clr && !fault |=> st_q == ST_RUN && !stat_q) // RULE_15
        else $error("clear did not release fault");

endmodule

/* File: verilog/ucfr_pkg.sv */
package ucfr_pkg;

    // ------------------------------------------------------------
    // Command codes and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  CMD_THRESHOLD   = 8'h4b;
    localparam logic [7:0]  CMD_ACTION      = 8'h4c;
    localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
    localparam logic [7:0]  ACTION_RESET    = 8'h00;

    // ------------------------------------------------------------
    // Action byte fields and threshold mantissa top bit
    // ------------------------------------------------------------
    localparam int RESP_MSB  = 7;
    localparam int RESP_LSB  = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DELAY_MSB = 2;
    localparam int DELAY_LSB = 0;
    localparam int MANT_MSB  = 10;

    localparam logic [1:0] RESP_IGNORE   = 2'h0;
    localparam logic [1:0] RESP_DELAY    = 2'h1;
    localparam logic [1:0] RESP_RETRY    = 2'h2;
    localparam logic [1:0] RESP_HOLD     = 2'h3;
    localparam logic [2:0] RETRY_NONE    = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_MHZ          = 125;
    localparam int CONT_UNIT_US       = 10000;
    localparam int RETRY_UNIT_US      = 8200;
    localparam int CONT_UNIT_CYCLES   = CONT_UNIT_US * CLOCK_MHZ;
    localparam int RETRY_UNIT_CYCLES  = RETRY_UNIT_US * CLOCK_MHZ;
    localparam int PRESCALE_W         = 21;

    // ------------------------------------------------------------
    // Response state machine
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_RUN   = 6'h01,
        ST_DELAY = 6'h02,
        ST_WAIT  = 6'h04,
        ST_TRY   = 6'h08,
        ST_LATCH = 6'h10,
        ST_HOLD  = 6'h20
    } ucfr_state_e;

endpackage

/* File: verilog/ucfr_timer_if.sv */
`timescale 1ns/100ps
interface ucfr_timer_if;
    logic       start;
    logic       retry_unit;
    logic [2:0] units;
    logic       done;

    modport ctrl (output start, output retry_unit, output units, input done);
    modport tmr  (input start, input retry_unit, input units, output done);
endinterface

/* File: verilog/ucfr_timer.sv */
`timescale 1ns/100ps
module ucfr_timer import ucfr_pkg::*; #(
    parameter int CONT_CYCLES  = CONT_UNIT_CYCLES,
    parameter int RETRY_CYCLES = RETRY_UNIT_CYCLES
) (
    input  wire logic  clock,
    input  wire logic  reset,
    ucfr_timer_if.tmr  tif
);

    logic                  busy_q, busy_d;
    logic                  sel_q, sel_d;
    logic                  done_q, done_d;
    logic [2:0]            left_q, left_d;
    logic [PRESCALE_W-1:0] pre_q, pre_d;
    logic [PRESCALE_W-1:0] limit;

    // ------------------------------------------------------------
    // Unit prescaler and unit counter
    // ------------------------------------------------------------
    // RULE_13 continue unit 10 ms
    // RULE_14 retry unit 8.2 ms
    assign limit = sel_q ? PRESCALE_W'(RETRY_CYCLES - 1) : PRESCALE_W'(CONT_CYCLES - 1);

    // Next values of the timer
    always_comb begin
        busy_d = busy_q;
        sel_d  = sel_q;
        left_d = left_q;
        pre_d  = pre_q;
        done_d = 1'b0;
        // RULE_12 field is unit count
        if (tif.start) begin
            busy_d = (tif.units != 3'h0);
            done_d = (tif.units == 3'h0);
            left_d = tif.units;
            sel_d  = tif.retry_unit;
            pre_d  = '0;
        end else if (busy_q) begin
            if (pre_q == limit) begin
                pre_d  = '0;
                left_d = left_q - 3'h1;
                if (left_q == 3'h1) begin
                    busy_d = 1'b0;
                    done_d = 1'b1;
                end
            end else begin
                pre_d = pre_q + PRESCALE_W'(1);
            end
        end
    end

    // Timer registers
    always_ff @(posedge clock) begin
        if (reset) begin
            busy_q <= 1'b0;
            sel_q  <= 1'b0;
            done_q <= 1'b0;
            left_q <= 3'h0;
            pre_q  <= '0;
        end else begin
            busy_q <= busy_d;
            sel_q  <= sel_d;
            done_q <= done_d;
            left_q <= left_d;
            pre_q  <= pre_d;
        end
    end

    assign tif.done = done_q;

    chk_zero_units: assert property (@(posedge clock) disable iff (reset) // RULE_12
        tif.start && tif.units == 3'h0 |=> tif.done)
        else $error("zero units did not finish at once");
    chk_done_single: assert property (@(posedge clock) disable iff (reset) // RULE_10
        tif.done && !tif.start |=> !tif.done)
        else $error("timer done lasted two cycles");

endmodule

/* File: verif/ucfr_host_model.sv */
`timescale 1ns/100ps
module ucfr_host_model (
    input  wire logic        clock,
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata,
    input  wire logic [15:0] cmd_rdata,
    input  wire logic        cmd_hit,
    output logic             clear_faults,
    output logic             status_uc_clear
);
    // Idle bus at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
        clear_faults = 1'b0;
        status_uc_clear = 1'b0;
    end

    // one command, answer one cycle on
    task automatic xfer(input logic [7:0] code, input logic wr, input logic [15:0] wd,
                        output logic [15:0] rd, output logic hit);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code = code;
        cmd_wdata = wd;
        @(posedge clock);
        #1;
        cmd_valid = 1'b0;
        cmd_wdata = ~wd; // Released bus shows no stale data
        rd = cmd_rdata;
        hit = cmd_hit;
        @(posedge clock);
        #1;
    endtask

    task automatic clear(input logic all);
        clear_faults = all;
        status_uc_clear = ~all;
        @(posedge clock);
        #1;
        clear_faults = 1'b0;
        status_uc_clear = 1'b0;
        @(posedge clock);
        #1;
    endtask
endmodule

/* File: verif/tb_undercurrent_fault_response.sv */
`timescale 1ns/100ps
module tb_undercurrent_fault_response;
    import ucfr_pkg::*;
    localparam int CC = 6;
    localparam int RC = 4;
    localparam logic [15:0] GOOD = 16'h00c8;
    localparam logic [15:0] BAD  = 16'h0032;

    typedef struct packed {
        logic [7:0]  code;
        logic        wr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic        hit;
    } ucfr_row_s;

    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        cmd_valid, cmd_write, cmd_hit, clear_faults, status_uc_clear;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, rd;
    logic [15:0] iout_meas = GOOD;
    logic        output_on_cmd = 1'b0;
    logic        other_fault_off = 1'b0;
    logic        output_enable, uc_fault_status, alert_out, alert_oe, hit;
    int          fails = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          r, t0, t1;
    ucfr_row_s   rows [9] = '{
        '{8'h4b, 1'b0, 16'h0000, 16'h0000, 1'b1}, '{8'h4c, 1'b0, 16'h0000, 16'h0000, 1'b1},
        '{8'h4b, 1'b1, 16'ha5c3, 16'h0000, 1'b1}, '{8'h4b, 1'b0, 16'h0000, 16'ha5c3, 1'b1},
        '{8'h4c, 1'b1, 16'hff96, 16'h0000, 1'b1}, '{8'h4c, 1'b0, 16'h0000, 16'h0096, 1'b1},
        '{8'h4d, 1'b1, 16'h1234, 16'h0000, 1'b0}, '{8'h4d, 1'b0, 16'h0000, 16'h0000, 1'b0},
        '{8'h4b, 1'b0, 16'h0000, 16'ha5c3, 1'b1}};

    // Clock and hang guard
    always #4 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end

    ucfr_host_model i_ucfr_host_model (.clock(clock), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_hit(cmd_hit),
        .clear_faults(clear_faults), .status_uc_clear(status_uc_clear));

    ucfr_top #(.CONT_CYCLES(CC), .RETRY_CYCLES(RC)) i_ucfr_top (.clock(clock), .reset(reset),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .cmd_rdata(cmd_rdata), .cmd_hit(cmd_hit), .iout_meas(iout_meas), .output_on_cmd(output_on_cmd),
        .clear_faults(clear_faults), .status_uc_clear(status_uc_clear), .other_fault_off(other_fault_off),
        .output_enable(output_enable), .uc_fault_status(uc_fault_status),
        .bus_alert_output_out(alert_out), .bus_alert_output_oe(alert_oe));

    // Helpers
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic act(input logic [7:0] a);
        i_ucfr_host_model.xfer(CMD_ACTION, 1'b1, {8'h00, a}, rd, hit);
    endtask

    task automatic watch(input int n, output int rises, output int f0, output int f1);
        logic prev;
        prev = output_enable;
        rises = 0;
        f0 = 0;
        f1 = 0;
        for (int i = 1; i <= n; i++) begin
            step(1);
            if (output_enable === 1'b1 && prev !== 1'b1) begin
                rises++;
                if (rises == 1) f0 = i;
                if (rises == 2) f1 = i;
            end
            prev = output_enable;
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        step(3);
        reset = 1'b0;
        chk(16'({alert_out, alert_oe, uc_fault_status, output_enable}), 16'h0000, "reset outputs");
        foreach (rows[k]) begin
            i_ucfr_host_model.xfer(rows[k].code, rows[k].wr, rows[k].wdata, rd, hit);
            chk(rd, rows[k].rdata, "read data");
            chk(16'(hit), 16'(rows[k].hit), "hit");
        end
        $display("register table done");
        i_ucfr_host_model.xfer(CMD_THRESHOLD, 1'b1, 16'h0064, rd, hit);
        output_on_cmd = 1'b1;
        act(8'h00);
        chk(16'(output_enable), 16'h0001, "enable on");
        iout_meas = BAD;
        step(2);
        chk(16'({alert_out, alert_oe, uc_fault_status}), 16'h0003, "alert low");
        step(20);
        chk(16'(output_enable), 16'h0001, "ignore mode");
        iout_meas = GOOD;
        step(2);
        chk(16'(uc_fault_status), 16'h0001, "sticky status");
        i_ucfr_host_model.clear(1'b0);
        chk(16'(uc_fault_status), 16'h0000, "bit clear");
        $display("ignore mode done");
        act(8'h80);
        iout_meas = BAD;
        step(2);
        chk(16'({uc_fault_status, output_enable}), 16'h0002, "disable at once");
        iout_meas = GOOD;
        step(40);
        chk(16'(output_enable), 16'h0000, "no retry");
        i_ucfr_host_model.clear(1'b1);
        step(2);
        chk(16'({uc_fault_status, output_enable}), 16'h0001, "clear all");
        $display("no retry done");
        act(8'h92);
        iout_meas = BAD;
        watch(200, r, t0, t1);
        chk(16'(r), 16'h0002, "two attempts");
        chk(16'(output_enable), 16'h0000, "latched off");
        n_tests++;
        if (t1 - t0 < 2 * RC || t1 - t0 > 2 * RC + 3) begin
            fails++;
            $display("Error at %0t: attempt spacing %0d", $time, t1 - t0);
        end
        iout_meas = GOOD;
        output_on_cmd = 1'b0;
        step(3);
        output_on_cmd = 1'b1;
        step(3);
        chk(16'({uc_fault_status, output_enable}), 16'h0001, "off then on");
        $display("counted retry done");
        act(8'hb9);
        iout_meas = BAD;
        watch(200, r, t0, t1);
        chk(16'(r > 6), 16'h0001, "endless retry");
        other_fault_off = 1'b1;
        step(5);
        watch(60, r, t0, t1);
        chk({15'(r), output_enable}, 16'h0000, "other fault stops");
        other_fault_off = 1'b0;
        iout_meas = GOOD;
        i_ucfr_host_model.clear(1'b1);
        $display("endless retry done");
        act(8'hc0);
        iout_meas = BAD;
        step(2);
        chk(16'(output_enable), 16'h0000, "hold off");
        step(20);
        chk(16'({uc_fault_status, output_enable}), 16'h0002, "hold while fault");
        iout_meas = GOOD;
        watch(100, r, t0, t1);
        chk(16'(output_enable), 16'h0001, "hold resumes");
        i_ucfr_host_model.clear(1'b1);
        $display("hold mode done");
        act(8'h42);
        step(2);
        iout_meas = BAD;
        step(2 * CC + 1);
        chk(16'({uc_fault_status, output_enable}), 16'h0003, "keeps running");
        step(1);
        chk(16'(output_enable), 16'h0000, "off after delay");
        $display("delayed mode done");
        iout_meas = GOOD;
        reset = 1'b1;
        step(3);
        reset = 1'b0;
        chk(16'({uc_fault_status, alert_oe, output_enable}), 16'h0000, "mid-run reset");
        i_ucfr_host_model.xfer(CMD_THRESHOLD, 1'b0, 16'h0000, rd, hit);
        chk(rd, THRESHOLD_RESET, "threshold after reset");
        chk(16'(output_enable), 16'h0001, "restart after reset");
        $display("mid-run reset done");
        finish_test();
    end
endmodule
